// File: fcs_regs.svh
// Register offsets, field positions, reset values and address map of the flash controller
//
// Notes on behaviour
// - Writes to unmapped or reserved offsets are ignored; unmapped reads return zero.
// - Program flash is decoded only at 0x78_0000 to 0x78_FFFF and 0x7F_0000 to 0x7F_FFFF.
// - Block 0 is 64 KB at 0x7F_0000 with config field; block 1 at 0x78_0000.
// - Lower, higher and remaining regions can each be activated for protection.
// - An 8-byte backdoor key sits at 0x7F_FF00 in the config field.
// - Protection bytes at 0x7F_FF0C and 0x7F_FF0D, option byte at 0x7F_FF0E.
// - The 3-bit command index selects the parameter word accessed next.
// - Command index register: only the index field is writable; other bits read zero.
// - ECC index field selects the result word read; other bits read zero.
// - Command-complete interrupt is requested while enabled and the complete flag is set.
// - Ignore-single-fault set suppresses single-fault reporting and its interrupt.
// - Config register keeps only enable, ignore and two force bits; others read zero.
// - Launch erases and verifies all flash; security released only on clean verify.
// - Command-complete flag is set when the unsecure operation finishes.
// - Access error at launch on nonzero index, active load sequence, unavailable mode or a command code other than unsecure.
// - Protection violation at launch while any program flash area is protected.
// - Verify sets error flag 1 on any error and flag 0 on uncorrectable errors.
// - Emulated violation flag set at launch while emulated partition is protected.
// - Program protection register is loaded from the config protection byte at reset.
// - Protection writes may only clear enable bits; a range size changes only while that range is off.
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
// Register offsets
`define FCS_A_CMDIX   8'h02
`define FCS_A_ECCIX   8'h03
`define FCS_A_CONFIG  8'h04
`define FCS_A_STATUS  8'h06
`define FCS_A_ERRSTAT 8'h07
`define FCS_A_PPROT   8'h08
`define FCS_A_EMULATED_PROTECTION_REG   8'h09
`define FCS_A_CMD_HI  8'h0b
`define FCS_A_CMD_LO  8'h0c
`define FCS_A_ECC_HI  8'h0d
`define FCS_A_ECC_LO  8'h0e
`define FCS_A_OPT     8'h0f
// Field positions and masks
`define FCS_M_INDEX   8'h07
`define FCS_M_CONFIG  8'h93
`define FCS_B_CMD_COMPLETE_IRQ_ENABLE    7
`define FCS_B_IGNORE_SINGLE_FAULT   4
`define FCS_B_FDF     1
`define FCS_B_FSF     0
`define FCS_B_CMD_COMPLETE_FLAG    7
`define FCS_B_ACCESS_ERROR_FLAG  5
`define FCS_B_PVIOL   4
`define FCS_B_VERR1   1
`define FCS_B_VERR0   0
`define FCS_B_EVIOL   4
`define FCS_B_DFAULT  1
`define FCS_B_SFAULT  0
`define FCS_B_EOPEN   7
`define FCS_B_EDIS    3
// Reset values and unsecure command code
`define FCS_R_ZERO8   8'h00
`define FCS_R_ZERO16  16'h0000
`define FCS_R_PROT    8'hff
`define FCS_CMD_UNSEC 8'h0b
// Global address map
`define FCS_PF_LO     23'h780000
`define FCS_BLK0_TAG  7'h7f
`define FCS_BLK1_TAG  7'h78
`define FCS_LOW_BASE  24'h7f8000
`define FCS_TOP_END   24'h800000
`define FCS_UNIT      24'h000800
`define FCS_CFG_TAG   19'h7fff0
`define FCS_KEY_BASE  23'h7fff00
`define FCS_KEY_LAST  23'h7fff07
`define FCS_PROT_ADR  23'h7fff0c
`define FCS_EMULATED_PROTECTION_REG_ADR 23'h7fff0d
`define FCS_OPT_ADR   23'h7fff0e
`endif

// File: fcs_pkg.sv
// Types shared by the flash controller
package fcs_pkg;
  typedef enum logic [1:0] {
    FCS_IDLE  = 2'b00,
    FCS_ERASE = 2'b01,
    FCS_WAIT  = 2'b11,
    FCS_DONE  = 2'b10
  } fcs_state_t;

  typedef struct packed {
    logic       open;
    logic       rsv;
    logic       hdis;
    logic [1:0] hs;
    logic       ldis;
    logic [1:0] ls;
  } fcs_pprot_t;

  typedef struct packed {
    logic done;
    logic err;
    logic nc;
  } fcs_erase_resp_t;
endpackage : fcs_pkg

// File: fcs_ctrl.sv
// Flash register block, address decode, protection and unsecure sequencer
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_ctrl #(
  parameter int WORDS = 8
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [7:0]               addr,
  input  wire logic [7:0]               wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [7:0]               rdata_q,
  input  wire logic [22:0]              pf_addr,
  output logic                          pf_hit_q,
  output logic                          pf_blk1_q,
  output logic                          pf_cfg_q,
  output logic                          pf_key_q,
  output logic                          pf_prot_q,
  input  wire logic [7:0]               cfg_pprot,
  input  wire logic [7:0]               cfg_emulated_protection_reg,
  input  wire logic [7:0]               cfg_opt,
  input  wire logic                     cfg_secured,
  input  wire logic                     load_active,
  input  wire logic                     cmd_allowed,
  output logic                          erase_req_q,
  input  wire fcs_pkg::fcs_erase_resp_t ers,
  input  wire logic                     sfault,
  input  wire logic                     dfault,
  input  wire logic [15:0]              fault_addr,
  output logic                          force_sf_q,
  output logic                          force_df_q,
  output logic                          irq_cmd_q,
  output logic                          irq_sf_q,
  output logic                          irq_df_q,
  output logic                          secured_q
);
  ////////////////////////////////////////////////////////////////////////////
  fcs_pkg::fcs_state_t state_q, state_d;
  fcs_pkg::fcs_pprot_t pprot_q, pprot_d, pw;
  logic [7:0]  emulated_protection_reg_q, emulated_protection_reg_d;
  logic [7:0]  opt_q, opt_d;
  logic [2:0]  cmdix_q, cmdix_d;
  logic [2:0]  eccix_q, eccix_d;
  logic [7:0]  config_q, config_d;
  logic        init_q, init_d;
  logic        cmd_complete_flag_q, cmd_complete_flag_d;
  logic        access_error_flag_q, access_error_flag_d;
  logic        pviol_q, pviol_d;
  logic        verr1_q, verr1_d;
  logic        verr0_q, verr0_d;
  logic        eviol_q, eviol_d;
  logic        sflag_q, sflag_d;
  logic        dflag_q, dflag_d;
  logic        secure_d;
  logic        erase_req_d;
  logic [7:0]  rdata_d;
  logic [15:0] cmd_mem [WORDS];
  logic [15:0] ecc_mem [WORDS];
  logic        wr_ok, launch, acc_bad, any_pprot, any_emulated_protection_reg, sf_rep;
  logic        hi_hit, lo_hit, in_reg, prot_d;
  logic        hit_d, blk1_d, cfg_d, key_d;
  logic [23:0] a24;

  ////////////////////////////////////////////////////////////////////////////
  // Launch checks and sequencer
  // Writes are ignored while busy or before the config bytes are loaded
  assign wr_ok     = wr && init_q && (state_q == fcs_pkg::FCS_IDLE);
  assign launch    = wr_ok && (addr == `FCS_A_STATUS) && wdata[`FCS_B_CMD_COMPLETE_FLAG] && cmd_complete_flag_q;
  assign any_pprot = !pprot_q.open || !pprot_q.hdis || !pprot_q.ldis;
  assign any_emulated_protection_reg = !emulated_protection_reg_q[`FCS_B_EOPEN] || !emulated_protection_reg_q[`FCS_B_EDIS];
  assign acc_bad   = (cmdix_q != 3'h0) || load_active || !cmd_allowed
                  || (cmd_mem[0][15:8] != `FCS_CMD_UNSEC);
  assign sf_rep    = sfault && !config_q[`FCS_B_IGNORE_SINGLE_FAULT];
  assign pw        = fcs_pkg::fcs_pprot_t'(wdata);

  always_comb begin
    state_d     = state_q;
    init_d      = 1'b1;
    cmd_complete_flag_d      = cmd_complete_flag_q;
    access_error_flag_d    = access_error_flag_q;
    pviol_d     = pviol_q;
    verr1_d     = verr1_q;
    verr0_d     = verr0_q;
    eviol_d     = eviol_q;
    sflag_d     = sflag_q;
    dflag_d     = dflag_q;
    secure_d    = secured_q;
    erase_req_d = 1'b0;
    pprot_d     = pprot_q;
    emulated_protection_reg_d     = emulated_protection_reg_q;
    opt_d       = opt_q;
    cmdix_d     = cmdix_q;
    eccix_d     = eccix_q;
    config_d    = config_q;
    if (!init_q) begin
      pprot_d  = fcs_pkg::fcs_pprot_t'(cfg_pprot);
      emulated_protection_reg_d  = cfg_emulated_protection_reg;
      opt_d    = cfg_opt;
      secure_d = cfg_secured;
      cmd_complete_flag_d   = 1'b1;
    end
    // Software writes, write-one-to-clear on flags
    if (wr_ok) begin
      case (addr)
        `FCS_A_CMDIX:  cmdix_d = wdata[2:0];
        `FCS_A_ECCIX:  eccix_d = wdata[2:0];
        `FCS_A_CONFIG: config_d = wdata & `FCS_M_CONFIG;
        `FCS_A_STATUS: begin
          if (wdata[`FCS_B_ACCESS_ERROR_FLAG]) access_error_flag_d = 1'b0;
          if (wdata[`FCS_B_PVIOL])  pviol_d  = 1'b0;
          if (wdata[`FCS_B_VERR1])  verr1_d  = 1'b0;
          if (wdata[`FCS_B_VERR0])  verr0_d  = 1'b0;
        end
        `FCS_A_ERRSTAT: begin
          if (wdata[`FCS_B_EVIOL])  eviol_d = 1'b0;
          if (wdata[`FCS_B_DFAULT]) dflag_d = 1'b0;
          if (wdata[`FCS_B_SFAULT]) sflag_d = 1'b0;
        end
        `FCS_A_PPROT: begin
          // Enable bits may only drop; sizes move only while their range is off
          pprot_d.open = pprot_q.open & pw.open;
          pprot_d.hdis = pprot_q.hdis & pw.hdis;
          pprot_d.ldis = pprot_q.ldis & pw.ldis;
          if (pprot_q.hdis) pprot_d.hs = pw.hs;
          if (pprot_q.ldis) pprot_d.ls = pw.ls;
        end
        `FCS_A_EMULATED_PROTECTION_REG: emulated_protection_reg_d = emulated_protection_reg_q & wdata;
        default: ;
      endcase
    end
    // Fault events win over a clear in the same cycle
    if (sf_rep) sflag_d = 1'b1;
    if (dfault) dflag_d = 1'b1;
    case (state_q)
      fcs_pkg::FCS_IDLE: begin
        if (launch) begin
          if (acc_bad) access_error_flag_d = 1'b1;
          if (any_pprot) pviol_d = 1'b1;
          if (any_emulated_protection_reg) eviol_d = 1'b1;
          if (!(acc_bad || any_pprot || any_emulated_protection_reg)) begin
            cmd_complete_flag_d  = 1'b0;
            state_d = fcs_pkg::FCS_ERASE;
          end
        end
      end
      fcs_pkg::FCS_ERASE: begin
        erase_req_d = 1'b1;
        state_d     = fcs_pkg::FCS_WAIT;
      end
      fcs_pkg::FCS_WAIT: begin
        if (ers.done) begin
          if (ers.err) verr1_d = 1'b1;
          if (ers.nc)  verr0_d = 1'b1;
          if (!ers.err && !ers.nc) secure_d = 1'b0;
          state_d = fcs_pkg::FCS_DONE;
        end
      end
      fcs_pkg::FCS_DONE: begin
        cmd_complete_flag_d  = 1'b1;
        state_d = fcs_pkg::FCS_IDLE;
      end
      default: state_d = fcs_pkg::FCS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q     <= fcs_pkg::FCS_IDLE;
      init_q      <= 1'b0;
      cmd_complete_flag_q      <= 1'b0;
      access_error_flag_q    <= 1'b0;
      pviol_q     <= 1'b0;
      verr1_q     <= 1'b0;
      verr0_q     <= 1'b0;
      eviol_q     <= 1'b0;
      sflag_q     <= 1'b0;
      dflag_q     <= 1'b0;
      secured_q   <= 1'b1;
      erase_req_q <= 1'b0;
      pprot_q     <= fcs_pkg::fcs_pprot_t'(`FCS_R_PROT);
      emulated_protection_reg_q     <= `FCS_R_PROT;
      opt_q       <= `FCS_R_ZERO8;
      cmdix_q     <= 3'h0;
      eccix_q     <= 3'h0;
      config_q    <= `FCS_R_ZERO8;
    end else begin
      state_q     <= state_d;
      init_q      <= init_d;
      cmd_complete_flag_q      <= cmd_complete_flag_d;
      access_error_flag_q    <= access_error_flag_d;
      pviol_q     <= pviol_d;
      verr1_q     <= verr1_d;
      verr0_q     <= verr0_d;
      eviol_q     <= eviol_d;
      sflag_q     <= sflag_d;
      dflag_q     <= dflag_d;
      secured_q   <= secure_d;
      erase_req_q <= erase_req_d;
      pprot_q     <= pprot_d;
      emulated_protection_reg_q     <= emulated_protection_reg_d;
      opt_q       <= opt_d;
      cmdix_q     <= cmdix_d;
      eccix_q     <= eccix_d;
      config_q    <= config_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter and fault result arrays
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < WORDS; i++) begin
        cmd_mem[i] <= `FCS_R_ZERO16;
        ecc_mem[i] <= `FCS_R_ZERO16;
      end
    end else begin
      if (wr_ok && addr == `FCS_A_CMD_HI) cmd_mem[cmdix_q][15:8] <= wdata;
      if (wr_ok && addr == `FCS_A_CMD_LO) cmd_mem[cmdix_q][7:0]  <= wdata;
      if (sf_rep || dfault) begin
        ecc_mem[0] <= fault_addr;
        ecc_mem[1] <= {14'h0000, dfault, sf_rep};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and outputs
  always_comb begin
    rdata_d = `FCS_R_ZERO8;
    if (rd) begin
      case (addr)
        `FCS_A_CMDIX:   rdata_d = {5'h00, cmdix_q};
        `FCS_A_ECCIX:   rdata_d = {5'h00, eccix_q};
        `FCS_A_CONFIG:  rdata_d = config_q;
        `FCS_A_STATUS:  rdata_d = {cmd_complete_flag_q, 1'b0, access_error_flag_q, pviol_q, 2'h0, verr1_q, verr0_q};
        `FCS_A_ERRSTAT: rdata_d = {3'h0, eviol_q, 2'h0, dflag_q, sflag_q};
        `FCS_A_PPROT:   rdata_d = pprot_q;
        `FCS_A_EMULATED_PROTECTION_REG:   rdata_d = emulated_protection_reg_q;
        `FCS_A_OPT:     rdata_d = opt_q;
        `FCS_A_CMD_HI:  rdata_d = cmd_mem[cmdix_q][15:8];
        `FCS_A_CMD_LO:  rdata_d = cmd_mem[cmdix_q][7:0];
        `FCS_A_ECC_HI:  rdata_d = ecc_mem[eccix_q][15:8];
        `FCS_A_ECC_LO:  rdata_d = ecc_mem[eccix_q][7:0];
        default:        rdata_d = `FCS_R_ZERO8;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q    <= `FCS_R_ZERO8;
      irq_cmd_q  <= 1'b0;
      irq_sf_q   <= 1'b0;
      irq_df_q   <= 1'b0;
      force_sf_q <= 1'b0;
      force_df_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      irq_cmd_q  <= config_q[`FCS_B_CMD_COMPLETE_IRQ_ENABLE] && cmd_complete_flag_q;
      irq_sf_q   <= sflag_q && !config_q[`FCS_B_IGNORE_SINGLE_FAULT];
      irq_df_q   <= dflag_q;
      force_sf_q <= config_q[`FCS_B_FSF];
      force_df_q <= config_q[`FCS_B_FDF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program flash address decode and protection lookup
  always_comb begin
    a24    = {1'b0, pf_addr};
    blk1_d = pf_addr[22:16] == `FCS_BLK1_TAG;
    hit_d  = (pf_addr >= `FCS_PF_LO)
          && (blk1_d || pf_addr[22:16] == `FCS_BLK0_TAG);
    cfg_d  = pf_addr[22:4] == `FCS_CFG_TAG;
    key_d  = (pf_addr >= `FCS_KEY_BASE) && (pf_addr <= `FCS_KEY_LAST);
    hi_hit = a24 >= (`FCS_TOP_END - (`FCS_UNIT << pprot_q.hs));
    lo_hit = (a24 >= `FCS_LOW_BASE)
          && (a24 < (`FCS_LOW_BASE + (`FCS_UNIT << pprot_q.ls)));
    in_reg = (hi_hit && !pprot_q.hdis) || (lo_hit && !pprot_q.ldis);
    prot_d = hit_d && (pprot_q.open ? in_reg : !in_reg);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pf_hit_q  <= 1'b0;
      pf_blk1_q <= 1'b0;
      pf_cfg_q  <= 1'b0;
      pf_key_q  <= 1'b0;
      pf_prot_q <= 1'b0;
    end else begin
      pf_hit_q  <= hit_d;
      pf_blk1_q <= hit_d && blk1_d;
      pf_cfg_q  <= cfg_d;
      pf_key_q  <= key_d;
      pf_prot_q <= prot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_good_launch;
    launch && !acc_bad && !any_pprot && !any_emulated_protection_reg;
  endsequence
  sequence s_erase_start;
    !cmd_complete_flag_q && state_q == fcs_pkg::FCS_ERASE ##1 erase_req_q;
  endsequence
  sequence s_finish;
    state_q == fcs_pkg::FCS_WAIT && ers.done;
  endsequence

  unmapped_read_zero_a: assert property (
    rd && addr == 8'h01 |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");
  launch_starts_erase_a: assert property (
    s_good_launch |=> s_erase_start)
    else $error("good launch did not start erase");
  finish_sets_cmd_complete_flag_a: assert property (
    s_finish |=> ##1 cmd_complete_flag_q && state_q == fcs_pkg::FCS_IDLE)
    else $error("complete flag not set after finish");
  bad_index_refused_a: assert property (
    launch && cmdix_q != 3'h0 |=> (access_error_flag_q && cmd_complete_flag_q && !erase_req_q)[*3])
    else $error("bad index launch not refused");
  protected_launch_a: assert property (
    launch && any_pprot |=> pviol_q && state_q == fcs_pkg::FCS_IDLE)
    else $error("protected launch not flagged");
  eeprom_viol_a: assert property (
    launch && any_emulated_protection_reg |=> eviol_q)
    else $error("emulated violation not flagged");
  verify_err_flag_a: assert property (
    (s_finish and ers.err) |=> verr1_q && $stable(secured_q))
    else $error("verify error not flagged");
  prot_no_shrink_a: assert property (
    !pprot_q.open |=> !pprot_q.open)
    else $error("protection enable reopened");
  cmd_irq_follow_a: assert property (
    cmd_complete_flag_q && config_q[`FCS_B_CMD_COMPLETE_IRQ_ENABLE] ##1 cmd_complete_flag_q |-> irq_cmd_q)
    else $error("command interrupt missing");
  index_high_zero_a: assert property (
    rd && addr == `FCS_A_CMDIX |=> rdata_q[7:3] == 5'h00)
    else $error("index upper bits not zero");
  ignored_sfault_a: assert property (
    config_q[`FCS_B_IGNORE_SINGLE_FAULT] && !sflag_q |=> !sflag_q)
    else $error("ignored single fault reported");
  busy_write_ignored_a: assert property (
    state_q != fcs_pkg::FCS_IDLE && wr && addr == `FCS_A_CONFIG |=> $stable(config_q))
    else $error("write during busy took effect");
  // Sequencer outputs, flags and copies of the config bits
  erase_pulse_a: assert property (
    erase_req_q |=> !erase_req_q)
    else $error("erase request longer than one cycle");
  clean_verify_a: assert property (
    (s_finish and (!ers.err && !ers.nc)) |=> !secured_q)
    else $error("clean verify did not release security");
  uncorr_flag_a: assert property (
    (s_finish and ers.nc) |=> verr0_q)
    else $error("uncorrectable verify error not flagged");
  busy_flag_low_a: assert property (
    state_q != fcs_pkg::FCS_IDLE |-> !cmd_complete_flag_q)
    else $error("complete flag high while busy");
  cmd_irq_off_a: assert property (
    !config_q[`FCS_B_CMD_COMPLETE_IRQ_ENABLE] |=> !irq_cmd_q)
    else $error("command interrupt while disabled");
  force_single_a: assert property (
    config_q[`FCS_B_FSF] |=> force_sf_q)
    else $error("force single fault not passed on");
  sfault_report_a: assert property (
    sfault && !config_q[`FCS_B_IGNORE_SINGLE_FAULT] |=> sflag_q)
    else $error("single fault not reported");
  access_abort_a: assert property (
    launch && acc_bad |=> cmd_complete_flag_q && state_q == fcs_pkg::FCS_IDLE)
    else $error("refused launch did not stay idle");
endmodule : fcs_ctrl

// File: fcs_ctrl_bench.sv
// Self-checking testbench for the flash register block and unsecure sequencer
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_ctrl_bench;
  logic                     clk         = 1'b0;
  logic                     nrst        = 1'b0;
  logic [7:0]               addr        = 8'h00;
  logic [7:0]               wdata       = 8'h00;
  logic                     wr          = 1'b0;
  logic                     rd          = 1'b0;
  logic [7:0]               rdata_q;
  logic [22:0]              pf_addr     = 23'h000000;
  logic                     pf_hit_q, pf_blk1_q, pf_cfg_q, pf_key_q, pf_prot_q;
  logic [7:0]               cfg_pprot   = 8'hff;
  logic [7:0]               cfg_emulated_protection_reg   = 8'hff;
  logic [7:0]               cfg_opt     = 8'ha5;
  logic                     cfg_secured = 1'b1;
  logic                     load_active = 1'b0;
  logic                     cmd_allowed = 1'b1;
  logic                     erase_req_q;
  fcs_pkg::fcs_erase_resp_t ers         = '0;
  logic                     sfault      = 1'b0;
  logic                     dfault      = 1'b0;
  logic [15:0]              fault_addr  = 16'h0000;
  logic                     force_sf_q, force_df_q, irq_cmd_q, irq_sf_q, irq_df_q, secured_q;
  int                       err_total   = 0;
  int                       n_tests     = 0;
  int                       cyc         = 0;

  fcs_ctrl uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .pf_addr(pf_addr), .pf_hit_q(pf_hit_q), .pf_blk1_q(pf_blk1_q),
    .pf_cfg_q(pf_cfg_q), .pf_key_q(pf_key_q), .pf_prot_q(pf_prot_q), .cfg_pprot(cfg_pprot),
    .cfg_emulated_protection_reg(cfg_emulated_protection_reg), .cfg_opt(cfg_opt), .cfg_secured(cfg_secured),
    .load_active(load_active), .cmd_allowed(cmd_allowed), .erase_req_q(erase_req_q),
    .ers(ers), .sfault(sfault), .dfault(dfault), .fault_addr(fault_addr),
    .force_sf_q(force_sf_q), .force_df_q(force_df_q), .irq_cmd_q(irq_cmd_q),
    .irq_sf_q(irq_sf_q), .irq_df_q(irq_df_q), .secured_q(secured_q));

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data are looked at mid-cycle, in the single cycle they stand
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata_q}, {8'h00, exp});
  endtask : rd_chk

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  // Expected bits: hit, block 1, config field, key, protected
  task automatic dec(input logic [22:0] a, input logic [4:0] exp);
    @(posedge clk);
    pf_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk({11'h0, pf_hit_q, pf_blk1_q, pf_cfg_q, pf_key_q, pf_prot_q}, {11'h0, exp});
  endtask : dec

  // Launch, watch for the erase request, answer it with the given verify result
  task automatic run_cmd(input logic [1:0] res, input logic go, input logic [7:0] st);
    logic seen;
    seen = 1'b0;
    wr_reg(`FCS_A_STATUS, 8'h80);
    repeat (4) begin
      @(negedge clk);
      if (erase_req_q === 1'b1) seen = 1'b1;
    end
    chk({15'h0, seen}, {15'h0, go});
    if (go) begin
      @(posedge clk);
      ers <= {1'b1, res};
      @(posedge clk);
      ers <= '0;
      repeat (3) @(posedge clk);
    end
    rd_chk(`FCS_A_STATUS, st);
  endtask : run_cmd

  task automatic fault(input logic s, input logic [15:0] fa);
    @(posedge clk);
    sfault     <= s;
    dfault     <= ~s;
    fault_addr <= fa;
    @(posedge clk);
    sfault     <= 1'b0;
    dfault     <= 1'b0;
  endtask : fault

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk(`FCS_A_STATUS, 8'h80);
    rd_chk(`FCS_A_OPT, 8'ha5);
    wr_reg(`FCS_A_CMDIX, 8'hff);
    rd_chk(`FCS_A_CMDIX, 8'h07);
    wr_reg(`FCS_A_ECCIX, 8'hff);
    rd_chk(`FCS_A_ECCIX, 8'h07);
    wr_reg(`FCS_A_CONFIG, 8'hff);
    rd_chk(`FCS_A_CONFIG, 8'h93);
    wr_reg(8'h01, 8'hff);
    wr_reg(8'h05, 8'h00);
    rd_chk(`FCS_A_CONFIG, 8'h93);
    rd_chk(8'h01, 8'h00);
    chk({14'h0, force_df_q, force_sf_q}, 16'h0003);
    chk({15'h0, irq_cmd_q}, 16'h0001);
    wr_reg(`FCS_A_CONFIG, 8'h00);
    repeat (2) @(posedge clk);
    chk({13'h0, irq_cmd_q, force_df_q, force_sf_q}, 16'h0000);
    wr_reg(`FCS_A_CMDIX, 8'h01);
    wr_reg(`FCS_A_CMD_HI, 8'h12);
    wr_reg(`FCS_A_CMD_LO, 8'h34);
    wr_reg(`FCS_A_CMDIX, 8'h00);
    wr_reg(`FCS_A_CMD_HI, `FCS_CMD_UNSEC);
    wr_reg(`FCS_A_CMD_LO, 8'h00);
    rd_chk(`FCS_A_CMD_HI, 8'h0b);
    wr_reg(`FCS_A_CMDIX, 8'h01);
    rd_chk(`FCS_A_CMD_HI, 8'h12);
    rd_chk(`FCS_A_CMD_LO, 8'h34);
  endtask : t_regs

  task automatic t_decode;
    dec(23'h7f0000, 5'b10000);
    dec(23'h7fff00, 5'b10110);
    dec(23'h7fff07, 5'b10110);
    dec(23'h7fff08, 5'b10100);
    dec(23'h7fff0f, 5'b10100);
    dec(23'h7fff10, 5'b10000);
    dec(23'h78ffff, 5'b11000);
    dec(23'h790000, 5'b00000);
    dec(23'h77ffff, 5'b00000);
  endtask : t_decode

  task automatic t_launch_err;
    for (int i = 0; i < 4; i++) begin
      wr_reg(`FCS_A_CMDIX, 8'h00);
      wr_reg(`FCS_A_CMD_HI, (i == 3) ? 8'h0c : 8'h0b);
      wr_reg(`FCS_A_CMDIX, (i == 0) ? 8'h01 : 8'h00);
      load_active <= (i == 1);
      cmd_allowed <= (i != 2);
      run_cmd(2'b00, 1'b0, 8'ha0);
      chk({15'h0, secured_q}, 16'h0001);
      load_active <= 1'b0;
      cmd_allowed <= 1'b1;
      rd_chk(`FCS_A_STATUS, 8'ha0);
      wr_reg(`FCS_A_STATUS, 8'h20);
    end
    wr_reg(`FCS_A_CMD_HI, `FCS_CMD_UNSEC);
  endtask : t_launch_err

  task automatic t_unsecure;
    wr_reg(`FCS_A_CONFIG, 8'h80);
    run_cmd(2'b11, 1'b1, 8'h83);
    chk({15'h0, secured_q}, 16'h0001);
    wr_reg(`FCS_A_STATUS, 8'h03);
    run_cmd(2'b10, 1'b1, 8'h82);
    wr_reg(`FCS_A_STATUS, 8'h03);
    run_cmd(2'b00, 1'b1, 8'h80);
    chk({14'h0, secured_q, irq_cmd_q}, 16'h0001);
  endtask : t_unsecure

  task automatic t_faults;
    wr_reg(`FCS_A_CONFIG, 8'h10);
    fault(1'b1, 16'hbeef);
    rd_chk(`FCS_A_ERRSTAT, 8'h00);
    chk({15'h0, irq_sf_q}, 16'h0000);
    wr_reg(`FCS_A_CONFIG, 8'h00);
    fault(1'b1, 16'h1234);
    wr_reg(`FCS_A_ECCIX, 8'h00);
    rd_chk(`FCS_A_ERRSTAT, 8'h01);
    chk({15'h0, irq_sf_q}, 16'h0001);
    rd_chk(`FCS_A_ECC_HI, 8'h12);
    rd_chk(`FCS_A_ECC_LO, 8'h34);
    fault(1'b0, 16'h0042);
    rd_chk(`FCS_A_ERRSTAT, 8'h03);
    chk({15'h0, irq_df_q}, 16'h0001);
    wr_reg(`FCS_A_ERRSTAT, 8'h03);
    rd_chk(`FCS_A_ERRSTAT, 8'h00);
  endtask : t_faults

  // Protection loaded at reset, enable bits only ever cleared, and blocking the unsecure launch
  task automatic t_protect;
    cfg_pprot <= 8'h7f;
    cfg_emulated_protection_reg <= 8'h77;
    cfg_opt   <= 8'h5a;
    do_reset();
    rd_chk(`FCS_A_PPROT, 8'h7f);
    rd_chk(`FCS_A_OPT, 8'h5a);
    wr_reg(`FCS_A_PPROT, 8'hff);
    rd_chk(`FCS_A_PPROT, 8'h7f);
    wr_reg(`FCS_A_PPROT, 8'h7b);
    rd_chk(`FCS_A_PPROT, 8'h7b);
    wr_reg(`FCS_A_EMULATED_PROTECTION_REG, 8'hff);
    rd_chk(`FCS_A_EMULATED_PROTECTION_REG, 8'h77);
    dec(23'h7f0000, 5'b10001);
    dec(23'h790000, 5'b00000);
    wr_reg(`FCS_A_CMDIX, 8'h00);
    wr_reg(`FCS_A_CMD_HI, `FCS_CMD_UNSEC);
    run_cmd(2'b00, 1'b0, 8'h90);
    rd_chk(`FCS_A_ERRSTAT, 8'h10);
    chk({15'h0, secured_q}, 16'h0001);
  endtask : t_protect

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    chk({15'h0, secured_q}, 16'h0001);
    do_reset();
    t_regs();
    t_decode();
    t_launch_err();
    t_unsecure();
    t_faults();
    t_protect();
    wrap_up();
  end
endmodule : fcs_ctrl_bench
